//--- fault_interrupt_status.sv
// Functional notes
// - Eight flags readable at 06h; open-drain low interrupt
// - Status read returns flags, then clears them
// - Bit 0 sets on indicator LED fault
// - Bit 1 sets on transformer fault
// - Bit 2 sets on boost converter fault
// - Bit 3 sets on charge or strobe timeout
// - Bit 4 sets on over-temperature trigger
// - Bit 5 sets on torch LED fault
// - Bit 6 sets when charge is done
// - Bit 7 sets on strobe self-test fault
// - Mask at 05h gates flags onto the interrupt only; resets enabled
// - Read clears flags without any host write
`timescale 1ns/1ps
`default_nettype none
module fault_interrupt_status #(
    parameter int WIDTH = flag_pkg::FLAG_COUNT
) (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RESET,
    // Register port from the serial control bus
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_RD,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    output var  logic [7:0] REG_RDATA,
    // Fault and event levels from the detectors
    input  wire logic       INDICATOR_LED_FAULT,
    input  wire logic       TRANSFORMER_FAULT,
    input  wire logic       BOOST_FAULT,
    input  wire logic       TIMEOUT_FAULT,
    input  wire logic       OVERTEMP_FAULT,
    input  wire logic       TORCH_LED_FAULT,
    input  wire logic       CHARGE_DONE,
    input  wire logic       SELFTEST_FAULT,
    // Open-drain interrupt pin, active low
    output var  logic       INT_N_O,
    output var  logic       INT_N_OE
);
    typedef struct packed {
        logic [WIDTH-1:0] status;
        logic [WIDTH-1:0] mask;
        logic [7:0]       rdata;
        logic             int_oe;
        logic             int_o;
    } ctrl_s;

    ctrl_s            st_r;
    ctrl_s            st_nxt;
    logic [WIDTH-1:0] raw_evt;
    logic             status_rd;
    logic             mask_rd;
    logic             mask_wr;

    event_if #(.WIDTH(WIDTH)) evt ();

    always_comb begin
        raw_evt = '0;
        raw_evt[flag_pkg::INDICATOR_LED_BIT] = INDICATOR_LED_FAULT;
        raw_evt[flag_pkg::TRANSFORMER_BIT]   = TRANSFORMER_FAULT;
        raw_evt[flag_pkg::BOOST_BIT]         = BOOST_FAULT;
        raw_evt[flag_pkg::TIMEOUT_BIT]       = TIMEOUT_FAULT;
        raw_evt[flag_pkg::OVERTEMP_BIT]      = OVERTEMP_FAULT;
        raw_evt[flag_pkg::TORCH_LED_BIT]     = TORCH_LED_FAULT;
        raw_evt[flag_pkg::CHARGE_DONE_BIT]   = CHARGE_DONE;
        raw_evt[flag_pkg::SELFTEST_BIT]      = SELFTEST_FAULT;
    end

    event_sync #(.WIDTH(WIDTH)) u_sync (
        .clk     (SYS_CLK),
        .rst     (RESET),
        .raw_evt (raw_evt),
        .evt     (evt)
    );

    assign status_rd = REG_RD && flag_pkg::reg_hit(REG_ADDR, flag_pkg::STATUS_OFFSET);
    assign mask_rd   = REG_RD && flag_pkg::reg_hit(REG_ADDR, flag_pkg::MASK_OFFSET);
    assign mask_wr   = REG_WR && flag_pkg::reg_hit(REG_ADDR, flag_pkg::MASK_OFFSET);

    always_comb begin
        st_nxt = st_r;
        // Read data, held until the next read
        if (status_rd) begin
            st_nxt.rdata = 8'(st_r.status);
        end else if (mask_rd) begin
            st_nxt.rdata = 8'(st_r.mask);
        end else if (REG_RD) begin
            st_nxt.rdata = flag_pkg::UNMAPPED_READ;
        end
        // Read clears what was returned; a new event in that cycle wins
        if (status_rd) begin
            st_nxt.status = '0;
        end
        st_nxt.status = st_nxt.status | evt.evt_pulse;
        if (mask_wr) begin
            st_nxt.mask = REG_WDATA[WIDTH-1:0];
        end
        st_nxt.int_oe = |(st_nxt.status & st_nxt.mask);
        // Open drain: the pin value is always low, only the enable moves
        st_nxt.int_o  = 1'b0;
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_r.status <= flag_pkg::STATUS_RESET[WIDTH-1:0];
            st_r.mask   <= flag_pkg::MASK_RESET[WIDTH-1:0];
            st_r.rdata  <= 8'h00;
            st_r.int_oe <= 1'b0;
            st_r.int_o  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA = st_r.rdata;
    assign INT_N_OE  = st_r.int_oe;
    assign INT_N_O   = st_r.int_o;

    status_read_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        status_rd |=> REG_RDATA == 8'($past(st_r.status)))
        else $error("status read returned wrong flags");

    read_clears_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        status_rd |=> (st_r.status & ~$past(evt.evt_pulse)) == '0)
        else $error("flags not cleared after status read");

    set_wins_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        |evt.evt_pulse |=> ($past(evt.evt_pulse) & ~st_r.status) == '0)
        else $error("event lost in flag register");

    led_fault_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!INDICATOR_LED_FAULT) [*3] ##1 INDICATOR_LED_FAULT [*5]
        |=> st_r.status[flag_pkg::INDICATOR_LED_BIT])
        else $error("indicator LED fault flag not set");

    no_spurious_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        !status_rd && !(|evt.evt_pulse) |=> st_r.status == $past(st_r.status))
        else $error("flags changed without read or event");

    mask_write_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        mask_wr |=> st_r.mask == $past(REG_WDATA[WIDTH-1:0]))
        else $error("mask write not taken");

    int_level_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        INT_N_OE == |(st_r.status & st_r.mask))
        else $error("interrupt drive disagrees with flags and mask");

    int_low_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        INT_N_OE |-> INT_N_O == 1'b0)
        else $error("interrupt pin driven high");

    // Each flag: three agreed lows, then a held rise, must set it
    trafo_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!TRANSFORMER_FAULT) [*3] ##1 TRANSFORMER_FAULT [*5]
        |=> st_r.status[flag_pkg::TRANSFORMER_BIT])
        else $error("transformer fault flag not set");

    boost_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!BOOST_FAULT) [*3] ##1 BOOST_FAULT [*5]
        |=> st_r.status[flag_pkg::BOOST_BIT])
        else $error("boost fault flag not set");

    timeout_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!TIMEOUT_FAULT) [*3] ##1 TIMEOUT_FAULT [*5]
        |=> st_r.status[flag_pkg::TIMEOUT_BIT])
        else $error("timeout fault flag not set");

    overtemp_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!OVERTEMP_FAULT) [*3] ##1 OVERTEMP_FAULT [*5]
        |=> st_r.status[flag_pkg::OVERTEMP_BIT])
        else $error("over-temperature flag not set");

    torch_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!TORCH_LED_FAULT) [*3] ##1 TORCH_LED_FAULT [*5]
        |=> st_r.status[flag_pkg::TORCH_LED_BIT])
        else $error("torch LED fault flag not set");

    charge_done_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!CHARGE_DONE) [*3] ##1 CHARGE_DONE [*5]
        |=> st_r.status[flag_pkg::CHARGE_DONE_BIT])
        else $error("charge done flag not set");

    selftest_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (!SELFTEST_FAULT) [*3] ##1 SELFTEST_FAULT [*5]
        |=> st_r.status[flag_pkg::SELFTEST_BIT])
        else $error("self-test fault flag not set");

    rdata_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");

    unmapped_read_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        REG_RD && !status_rd && !mask_rd |=> REG_RDATA == flag_pkg::UNMAPPED_READ)
        else $error("unmapped read returned nonzero data");

    mask_read_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        mask_rd |=> REG_RDATA == 8'($past(st_r.mask)))
        else $error("mask read returned wrong value");

    mask_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        !mask_wr |=> $stable(st_r.mask))
        else $error("mask changed without a write");

    int_release_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        status_rd && !(|evt.evt_pulse) |=> !INT_N_OE)
        else $error("interrupt still driven after status read");
endmodule
`default_nettype wire

//--- flag_pkg.sv
`default_nettype none
package flag_pkg;
    localparam logic [7:0] MASK_OFFSET       = 8'h05;
    localparam logic [7:0] STATUS_OFFSET     = 8'h06;
    localparam logic [7:0] MASK_RESET        = 8'hFF;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;
    localparam int         FLAG_COUNT        = 8;
    localparam int         INDICATOR_LED_BIT = 0;
    localparam int         TRANSFORMER_BIT   = 1;
    localparam int         BOOST_BIT         = 2;
    localparam int         TIMEOUT_BIT       = 3;
    localparam int         OVERTEMP_BIT      = 4;
    localparam int         TORCH_LED_BIT     = 5;
    localparam int         CHARGE_DONE_BIT   = 6;
    localparam int         SELFTEST_BIT      = 7;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction
endpackage
`default_nettype wire

//--- event_if.sv
`timescale 1ns/1ps
`default_nettype none
interface event_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] evt_pulse;
    modport src (output evt_pulse);
    modport dst (input evt_pulse);
endinterface
`default_nettype wire

//--- event_sync.sv
`timescale 1ns/1ps
`default_nettype none
module event_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Raw event levels from the detectors
    input  wire logic [WIDTH-1:0] raw_evt,
    // One-cycle pulse per new event
    event_if.src                  evt
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] pulse;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = raw_evt;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Level counts only once two stages agree
        for (int i = 0; i < WIDTH; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
        end
        st_nxt.pulse = st_nxt.stable & ~st_r.stable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.evt_pulse = st_r.pulse;
endmodule
`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       clk,
    // Register port toward the device
    output var  logic [7:0] addr,
    output var  logic       rd,
    output var  logic       wr,
    output var  logic [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        addr  = 8'h00;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = 8'h00;
    end

    // Released lines show the inverse of the last value
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~v;
        #1;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       SYS_CLK = 1'b0;
    logic       RESET   = 1'b1;
    logic [7:0] evt     = 8'h00;
    logic [7:0] REG_ADDR;
    logic [7:0] REG_WDATA;
    logic [7:0] REG_RDATA;
    logic [7:0] d;
    logic       REG_RD;
    logic       REG_WR;
    logic       INT_N_O;
    logic       INT_N_OE;
    int         errors     = 0;
    int         num_checks = 0;

    always #20 SYS_CLK = ~SYS_CLK;

    host_model host_model_inst (.clk(SYS_CLK), .addr(REG_ADDR), .rd(REG_RD), .wr(REG_WR),
        .wdata(REG_WDATA), .rdata(REG_RDATA));

    fault_interrupt_status fault_interrupt_status_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .INDICATOR_LED_FAULT(evt[0]), .TRANSFORMER_FAULT(evt[1]),
        .BOOST_FAULT(evt[2]), .TIMEOUT_FAULT(evt[3]), .OVERTEMP_FAULT(evt[4]),
        .TORCH_LED_FAULT(evt[5]), .CHARGE_DONE(evt[6]), .SELFTEST_FAULT(evt[7]),
        .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Bounded wait for the interrupt pin to be pulled
    task automatic wait_int();
        int n;
        n = 0;
        while (INT_N_OE !== 1'b1 && n < 8) begin
            @(posedge SYS_CLK);
            #1 n++;
        end
        if (INT_N_OE !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask

    initial begin
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'b0;
        host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
        chk(d, 8'h00);
        chk({6'h00, INT_N_OE, INT_N_O}, 8'h00);
        host_model_inst.rd_reg(flag_pkg::MASK_OFFSET, d);
        chk(d, 8'hFF);
        // One event source at a time, each read then cleared
        for (int i = 0; i < 8; i++) begin
            @(posedge SYS_CLK);
            evt <= 8'h01 << i;
            wait_int();
            chk({7'h00, INT_N_OE}, 8'h01);
            host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
            chk(d, 8'h01 << i);
            chk({7'h00, INT_N_OE}, 8'h00);
            host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
            chk(d, 8'h00);
            @(posedge SYS_CLK);
            evt <= 8'h00;
        end
        // All flags set while masked off
        host_model_inst.wr_reg(flag_pkg::MASK_OFFSET, 8'h00);
        @(posedge SYS_CLK);
        evt <= 8'hFF;
        repeat (6) @(posedge SYS_CLK);
        #1 chk({7'h00, INT_N_OE}, 8'h00);
        host_model_inst.wr_reg(flag_pkg::STATUS_OFFSET, 8'h00);
        host_model_inst.wr_reg(flag_pkg::MASK_OFFSET, 8'h80);
        chk({7'h00, INT_N_OE}, 8'h01);
        host_model_inst.rd_reg(flag_pkg::MASK_OFFSET, d);
        chk(d, 8'h80);
        host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
        chk(d, 8'hFF);
        chk({7'h00, INT_N_OE}, 8'h00);
        host_model_inst.rd_reg(8'h3C, d);
        chk(d, 8'h00);
        // Event landing with a status read stays pending
        @(posedge SYS_CLK);
        evt <= 8'h00;
        repeat (4) @(posedge SYS_CLK);
        evt <= 8'h80;
        repeat (3) @(posedge SYS_CLK);
        host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
        chk(d, 8'h00);
        chk({7'h00, INT_N_OE}, 8'h01);
        host_model_inst.rd_reg(flag_pkg::STATUS_OFFSET, d);
        chk(d, 8'h80);
        give_verdict();
    end
endmodule
`default_nettype wire
